// ===== hw/pvc_defs.svh
// constants for the phy vendor configuration register block
// Functional notes
// R1: bit 15 one bypasses 4B5B encoder and 5B4B decoder together.
// R2: bit 14 one bypasses transmit scrambler and receive descrambler.
// R3: bit 13 one bypasses descrambling, alignment, decoding, encoding and scrambling; it does not set bypass_code_conversion.
// R4: bit 12 one forces the signal detector active; debug only.
// R5: software writes zero to reserved bits 11 and 6.
// R6: bit 10 selects twisted pair when one, fiber when zero; resets to one.
// R7: bit 7 one forces a good 100 Mbit link status.
// R8: bit 5 drives the collision indicator only in test mode.
// R9: bit 4 resets to one and permits automatic reduced power down.
// R10: writing one to bit 3 resets all phy state machines.
// R11: bit 3 clears itself once the triggered reset has finished.
// R12: bit 2 resets to one and enables management preamble suppression.
// R13: writing one to bit 1 puts the phy to sleep except clocking.
// R14: waking from sleep restores configuration and resets state machines.
// R15: bit 0 one loops received data back out on transmit.
// R16: reads return every writable bit; reserved bit 9 reads zero.
`ifndef PVC_DEFS_SVH
`define PVC_DEFS_SVH
`define PVC_ADDR_CFG 12'h010
`define PVC_ADDR_STAT 12'h014
`define PVC_RESET_VAL 16'h0414
`define PVC_WR_MASK 16'hfdff
`define PVC_BIT_BP_CODE 15
`define PVC_BIT_BYPASS_SCRAMBLING 14
`define PVC_BIT_BP_SYM 13
`define PVC_BIT_FORCE_SD 12
`define PVC_BIT_RSV11 11
`define PVC_BIT_MEDIA 10
`define PVC_BIT_RSV9 9
`define PVC_BIT_FORCE_LINK 7
`define PVC_BIT_RSV6 6
`define PVC_BIT_COL 5
`define PVC_BIT_AUTO_LP 4
`define PVC_BIT_FSM_RST 3
`define PVC_BIT_PRE_SKIP 2
`define PVC_BIT_SLEEP 1
`define PVC_BIT_LOOP 0
`define PVC_RST_NS 80
`define PVC_CLK_NS 20
`define PVC_RST_CYC ((`PVC_RST_NS + `PVC_CLK_NS - 1) / `PVC_CLK_NS)
`define PVC_CNT_W 3
`endif

// ===== hw/pvc_pkg.sv
// types for the phy vendor configuration register block
package pvc_pkg;
    typedef enum logic [1:0] {
        PVC_RUN = 2'b00,
        PVC_RESET = 2'b01,
        PVC_SLEEP = 2'b10
    } pvc_state_e;
    typedef logic [15:0] pvc_word_t;
endpackage

// ===== hw/pvc_pulse_timer.sv
// fixed-length pulse generator used for the state machine reset
`timescale 1ns/1ps
`default_nettype none
`include "pvc_defs.svh"
module pvc_pulse_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic start,
    output logic busy,
    output logic done
);
    logic [`PVC_CNT_W-1:0] cnt;
    wire last_cnt = (cnt == `PVC_CNT_W'(1));
    // count down from start, pulse done on the last count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
        end else if (ce) begin
            if (start) begin
                cnt <= `PVC_CNT_W'(`PVC_RST_CYC);
            end else if (cnt != '0) begin
                cnt <= cnt - `PVC_CNT_W'(1);
            end
        end
    end
    assign busy = (cnt != '0);
    assign done = ce && last_cnt && !start;
endmodule // pvc_pulse_timer
`default_nettype wire

// ===== hw/pvc_config_reg.sv
// phy vendor configuration register with apb slave and control outputs
`timescale 1ns/1ps
`default_nettype none
`include "pvc_defs.svh"
module pvc_config_reg (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic test_mode,
    input wire logic raw_signal_detect,
    input wire logic raw_link_100,
    input wire logic auto_low_power_req,
    output logic bypass_code_conversion,
    output logic bypass_scrambling,
    output logic bypass_symbol_path,
    output logic signal_detector,
    output logic media_twisted_pair,
    output logic link_100_good,
    output logic collision_indicator,
    output logic low_power_active,
    output logic phy_fsm_reset,
    output logic preamble_skip_ctl,
    output logic sleep_active,
    output logic remote_loopback
);
    pvc_pkg::pvc_word_t cfg;
    pvc_pkg::pvc_word_t next_cfg;
    pvc_pkg::pvc_word_t saved_cfg;
    pvc_pkg::pvc_state_e state;
    pvc_pkg::pvc_state_e next_state;
    logic [31:0] next_prdata;
    logic tmr_busy;
    logic tmr_done;

    // apb decode
    wire acc = psel && penable && ce;
    wire hit_cfg = (paddr == `PVC_ADDR_CFG);
    wire hit_stat = (paddr == `PVC_ADDR_STAT);
    wire hit = hit_cfg || hit_stat;
    wire wr_cfg = acc && pwrite && hit_cfg;
    wire [15:0] lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    wire [15:0] wr_mask = lane_mask & `PVC_WR_MASK;
    wire [15:0] wdata = pwdata[15:0];
    wire fsm_start_wr = wr_cfg && pstrb[0] && wdata[`PVC_BIT_FSM_RST];
    wire sleep_set = wr_cfg && pstrb[0] && wdata[`PVC_BIT_SLEEP];
    wire wake = wr_cfg && pstrb[0] && !wdata[`PVC_BIT_SLEEP] && (state == pvc_pkg::PVC_SLEEP);
    wire tmr_start = fsm_start_wr || wake;
    wire [15:0] stat_word = {13'h0000, low_power_active, sleep_active, tmr_busy};

    // reset pulse length
    pvc_pulse_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .start(tmr_start),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    // register update: byte-lane write, self clearing reset bit, wake restore
    always_comb begin
        next_cfg = cfg;
        if (wake) begin
            // R14: restore saved config
            next_cfg = saved_cfg;
            next_cfg[`PVC_BIT_SLEEP] = 1'b0;
            next_cfg[`PVC_BIT_FSM_RST] = 1'b1;
        end else if (wr_cfg) begin
            next_cfg = (cfg & ~wr_mask) | (wdata & wr_mask);
        end
        // R11: self clear when done
        if (tmr_done && !fsm_start_wr) begin
            next_cfg[`PVC_BIT_FSM_RST] = 1'b0;
        end
        // R16: reserved bit reads zero
        next_cfg[`PVC_BIT_RSV9] = 1'b0;
    end

    // control state sequencing
    always_comb begin
        next_state = state;
        case (state)
            pvc_pkg::PVC_RUN: begin
                if (sleep_set) begin
                    next_state = pvc_pkg::PVC_SLEEP;
                end else if (fsm_start_wr) begin
                    next_state = pvc_pkg::PVC_RESET;
                end
            end
            pvc_pkg::PVC_RESET: begin
                if (sleep_set) begin
                    next_state = pvc_pkg::PVC_SLEEP;
                end else if (tmr_done) begin
                    next_state = pvc_pkg::PVC_RUN;
                end
            end
            pvc_pkg::PVC_SLEEP: begin
                if (wake) begin
                    next_state = pvc_pkg::PVC_RESET;
                end
            end
            default: begin
                next_state = pvc_pkg::PVC_RUN;
            end
        endcase
    end

    // apb read data
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (hit_cfg) begin
            next_prdata = {16'h0000, cfg};
        end else if (hit_stat) begin
            next_prdata = {16'h0000, stat_word};
        end
    end

    // register flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= `PVC_RESET_VAL;
            state <= pvc_pkg::PVC_RUN;
        end else if (ce) begin
            cfg <= next_cfg;
            state <= next_state;
        end
    end

    // configuration snapshot on sleep entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            saved_cfg <= `PVC_RESET_VAL;
        end else if (ce && sleep_set && state != pvc_pkg::PVC_SLEEP) begin
            saved_cfg <= cfg;
        end
    end

    // read data flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (ce && psel && !penable && !pwrite) begin
            prdata <= next_prdata;
        end
    end

    // zero wait state answer, error on unmapped address
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;

    // R1: code conversion bypass
    assign bypass_code_conversion = cfg[`PVC_BIT_BP_CODE];
    // R2: scrambler bypass
    assign bypass_scrambling = cfg[`PVC_BIT_BYPASS_SCRAMBLING] || cfg[`PVC_BIT_BP_SYM];
    // R3: symbol path bypass
    assign bypass_symbol_path = cfg[`PVC_BIT_BP_SYM];
    // R4: forced signal detect
    assign signal_detector = raw_signal_detect || cfg[`PVC_BIT_FORCE_SD];
    // R6: media select
    assign media_twisted_pair = cfg[`PVC_BIT_MEDIA];
    // R7: forced good link
    assign link_100_good = raw_link_100 || cfg[`PVC_BIT_FORCE_LINK];
    // R8: collision indicator test gating
    assign collision_indicator = test_mode && cfg[`PVC_BIT_COL];
    // R9: automatic low power gating
    assign low_power_active = auto_low_power_req && cfg[`PVC_BIT_AUTO_LP] && !sleep_active;
    // R10: state machine reset
    assign phy_fsm_reset = (state == pvc_pkg::PVC_RESET) || sleep_active;
    // R12: preamble suppression
    assign preamble_skip_ctl = cfg[`PVC_BIT_PRE_SKIP];
    // R13: sleep state
    assign sleep_active = (state == pvc_pkg::PVC_SLEEP);
    // R15: remote loopback
    assign remote_loopback = cfg[`PVC_BIT_LOOP];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_BP_CODE: assert property (bypass_code_conversion == cfg[`PVC_BIT_BP_CODE]) else $error("code bypass wrong"); // R1
    AST_BYPASS_SCRAMBLING: assert property (cfg[`PVC_BIT_BYPASS_SCRAMBLING] |-> bypass_scrambling) else $error("scrambler bypass missing"); // R2
    AST_BP_SYM: assert property (cfg[`PVC_BIT_BP_SYM] |-> bypass_symbol_path && bypass_scrambling)
        else $error("symbol bypass"); // R3
    AST_FORCE_SD: assert property (cfg[`PVC_BIT_FORCE_SD] |-> signal_detector)
        else $error("signal detect not forced"); // R4
    AST_MEDIA: assert property (media_twisted_pair == cfg[`PVC_BIT_MEDIA]) else $error("media select wrong"); // R6
    AST_LINK: assert property (!cfg[`PVC_BIT_FORCE_LINK] |-> link_100_good == raw_link_100)
        else $error("link not following line"); // R7
    AST_COL: assert property (!test_mode |-> !collision_indicator) else $error("collision outside test"); // R8
    AST_LP: assert property (!cfg[`PVC_BIT_AUTO_LP] |-> !low_power_active) else $error("low power while disabled"); // R9
    AST_RST: assert property (ce && fsm_start_wr && !sleep_set |=> phy_fsm_reset) else $error("no fsm reset"); // R10
    AST_SELFCLR: assert property (ce && fsm_start_wr && !sleep_set |-> ##[1:12] !cfg[`PVC_BIT_FSM_RST])
        else $error("reset bit stuck"); // R11
    AST_PRE: assert property (preamble_skip_ctl == cfg[`PVC_BIT_PRE_SKIP]) else $error("preamble ctl wrong"); // R12
    AST_SLEEP: assert property (ce && sleep_set |=> sleep_active) else $error("sleep not entered"); // R13
    AST_WAKE: assert property (ce && wake |=> !sleep_active && phy_fsm_reset
        && cfg == $past(saved_cfg | (16'h0001 << `PVC_BIT_FSM_RST))) else $error("wake restore wrong"); // R14
    AST_LOOP: assert property (remote_loopback == cfg[`PVC_BIT_LOOP]) else $error("loopback wrong"); // R15
    AST_RSV9: assert property (!cfg[`PVC_BIT_RSV9]) else $error("reserved bit set"); // R16
    COV_WRITE: cover property (wr_cfg);
    COV_FSM_RST: cover property (tmr_done);
    COV_SLEEP_WAKE: cover property (sleep_active ##[1:50] wake);
    COV_ERR: cover property (pslverr);
endmodule // pvc_config_reg
`default_nettype wire

// ===== sim/pvc_config_reg_tb_top.sv
// self-checking bench for the phy vendor configuration register
`timescale 1ns/1ps
`default_nettype none
module pvc_config_reg_tb_top;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, rd;
    logic tm = 1'b0, sd = 1'b0, lk = 1'b0, lp = 1'b0, ce = 1'b1, err;
    logic [15:0] c;
    wire [31:0] prdata;
    wire [9:0] o;
    wire pready, pslverr, fr, sl;
    int mismatches = 0, checked = 0;

    // 50 MHz clock
    always #10 pclk = ~pclk;

    pvc_config_reg i_pvc_config_reg (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .test_mode(tm), .raw_signal_detect(sd),
        .raw_link_100(lk), .auto_low_power_req(lp), .bypass_code_conversion(o[9]),
        .bypass_scrambling(o[8]), .bypass_symbol_path(o[7]), .signal_detector(o[6]),
        .media_twisted_pair(o[5]), .link_100_good(o[4]), .collision_indicator(o[3]),
        .low_power_active(o[2]), .phy_fsm_reset(fr), .preamble_skip_ctl(o[1]),
        .sleep_active(sl), .remote_loopback(o[0]));

    // compare and count
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // verdict and end of run
    task test_done;
        if (mismatches == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // expected control outputs for an awake register value
    function logic [9:0] exp_o(input logic [15:0] v);
        return {v[15], v[14] | v[13], v[13], sd | v[12], v[10], lk | v[7], tm & v[5], lp & v[4], v[2], v[0]};
    endfunction

    // one apb transfer, held until pready is seen high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
             output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            mismatches++;
            test_done;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // bounded wait for the state machine reset to end
    task wait_low;
        int n;
        n = 0;
        while (fr !== 1'b0 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20) begin
            mismatches++;
            test_done;
        end
    endtask

    // main sequence
    initial begin
        void'($urandom(73681));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        check("out_rst", o, exp_o(16'h0414));
        apb(1'b0, 12'h010, 32'h0000_0000, rd, err);
        check("cfg_rst", rd, 32'h0000_0414);
        // random values; reserved 11 and 6 kept zero, bit 9 written freely
        for (int i = 0; i < 40; i++) begin
            c = 16'($urandom) & 16'hf7b5;
            {tm, sd, lk, lp} <= 4'($urandom);
            apb(1'b1, 12'h010, {16'($urandom), c}, rd, err);
            #1;
            check("outs", o, exp_o(c));
            apb(1'b0, 12'h010, 32'h0000_0000, rd, err);
            check("cfg_rd", rd, {16'h0000, c & 16'hfdff});
        end
        // state machine reset pulse
        apb(1'b1, 12'h010, {16'h0000, c | 16'h0008}, rd, err);
        #1;
        check("fsm_rst", fr, 32'h0000_0001);
        wait_low;
        apb(1'b0, 12'h010, 32'h0000_0000, rd, err);
        check("fsm_clr", rd, {16'h0000, c & 16'hfdff});
        // sleep entry and wake
        lp <= 1'b1;
        apb(1'b1, 12'h010, {16'h0000, c | 16'h0002}, rd, err);
        #1;
        check("sleep", {sl, o[2]}, 32'h0000_0002);
        apb(1'b0, 12'h014, 32'h0000_0000, rd, err);
        check("stat_sleep", rd, 32'h0000_0002);
        apb(1'b1, 12'h010, {16'h0000, c}, rd, err);
        #1;
        check("wake", {sl, fr}, 32'h0000_0001);
        wait_low;
        apb(1'b0, 12'h010, 32'h0000_0000, rd, err);
        check("restore", rd, {16'h0000, c & 16'hfdff});
        // unmapped address is refused
        apb(1'b1, 12'h020, 32'hffff_ffff, rd, err);
        check("err_wr", err, 32'h0000_0001);
        apb(1'b0, 12'h020, 32'h0000_0000, rd, err);
        check("err_rd", err, 32'h0000_0001);
        check("err_data", rd, 32'h0000_0000);
        apb(1'b0, 12'h010, 32'h0000_0000, rd, err);
        check("kept", rd, {16'h0000, c & 16'hfdff});
        // clock enable low freezes the register against a write
        ce <= 1'b0;
        apb(1'b1, 12'h010, {16'h0000, ~c & 16'hf7b5}, rd, err);
        ce <= 1'b1;
        apb(1'b0, 12'h010, 32'h0000_0000, rd, err);
        check("frozen", rd, {16'h0000, c & 16'hfdff});
        test_done;
    end
endmodule // pvc_config_reg_tb_top
`default_nettype wire
